// [rtl/scs_pkg.sv]
/*
 * Shared constants for the scaler control/status register block:
 * register addresses, field positions, reset values and bus address.
 * Assumes an I2C-bus host reaches the registers by byte subaddress.
 */
package scs_pkg;
    localparam logic [7:0] SCS_ADDR_CTRL   = 8'h88;
    localparam logic [7:0] SCS_ADDR_STATUS = 8'h8f;
    localparam logic [7:0] SCS_ADDR_SET_A  = 8'h90;
    localparam logic [7:0] SCS_ADDR_SET_B  = 8'hc0;

    localparam logic [7:0] SCS_CTRL_RESET  = 8'h00;
    localparam logic [7:0] SCS_CTRL_WMASK  = 8'hfb;
    localparam logic [7:0] SCS_TASK_RESET  = 8'h00;
    localparam logic [7:0] SCS_TASK_WMASK  = 8'hf8;

    // Control register fields
    localparam int SCS_SEL_LSB     = 6;
    localparam int SCS_SCALER_SOFT_RESET_N_BIT   = 5;
    localparam int SCS_MARK_BIT    = 4;
    localparam int SCS_AUD_SLP_BIT = 3;
    localparam int SCS_SCL_SLP_BIT = 1;
    localparam int SCS_DEC_SLP_BIT = 0;

    // Status byte fields
    localparam int SCS_ST_EXPANSION_TRISTATE_PIN = 7;
    localparam int SCS_ST_IMAGE_TRISTATE_PIN = 6;
    localparam int SCS_ST_FIFO_ALMOST_FILLED = 5;
    localparam int SCS_ST_FIFO_OVERFLOW = 4;
    localparam int SCS_ST_MARK = 3;
    localparam int SCS_ST_ERR  = 2;
    localparam int SCS_ST_FIDI = 1;
    localparam int SCS_ST_FIDO = 0;

    // Task handling fields
    localparam int SCS_MSBINV_BIT = 7;
    localparam int SCS_OFID_BIT   = 6;
    localparam int SCS_SKIP_LSB   = 3;

    // Arbitrary bus device address
    localparam logic [6:0] SCS_I2C_DEV_ADDR = 7'h21;
    localparam int SCS_ADC_W = 9;
endpackage

// [rtl/scs_reg_if.sv]
/*
 * Byte register access channel between the serial slave and the bank.
 * Assumes both ends run on the same clock; we is a one-cycle pulse.
 */
`timescale 1ns/1ps
interface scs_reg_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       we;
    modport bus  (output addr, output wdata, output we, input rdata);
    modport regs (input addr, input wdata, input we, output rdata);
endinterface

// [rtl/scs_i2c_slave.sv]
/*
 * I2C-bus slave: device address, subaddress with auto-increment,
 * byte writes and reads over scs_reg_if.
 * Assumes SCL well below core_clk/8; pins are asynchronous.
 */
`timescale 1ns/1ps
module scs_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = scs_pkg::SCS_I2C_DEV_ADDR
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic sclPin,
    input  wire logic sdaIn,
    output logic      sdaOut,
    output logic      sdaOe,
    scs_reg_if.bus    regIf
);
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_DEV = 7'h02, S_DACK = 7'h04, S_WR = 7'h08,
        S_WACK = 7'h10, S_RD = 7'h20, S_RACK = 7'h40
    } scs_i2c_st_type;

    typedef struct packed {
        scs_i2c_st_type st;
        logic [2:0]     scl;
        logic [2:0]     sda;
        logic [7:0]     sh;
        logic [2:0]     cnt;
        logic           full;
        logic           rw;
        logic           haveSub;
        logic           acked;
        logic [7:0]     sub;
        logic           we;
        logic           oe;
    } scs_i2c_type;

    scs_i2c_type q, d;
    logic rise, fall, start, stop, sdaH;

    always_comb begin
        // Index 0 is the first sync stage, read only by index 1
        sdaH  = q.sda[1];
        rise  = q.scl[1] & ~q.scl[2];
        fall  = ~q.scl[1] & q.scl[2];
        start = q.scl[1] & q.scl[2] & q.sda[2] & ~q.sda[1];
        stop  = q.scl[1] & q.scl[2] & ~q.sda[2] & q.sda[1];
        d = q;
        d.we  = 1'b0;
        d.scl = {q.scl[1:0], sclPin};
        d.sda = {q.sda[1:0], sdaIn};
        if (rise && (q.st == S_DEV || q.st == S_WR)) begin
            d.sh  = {q.sh[6:0], sdaH};
            d.cnt = q.cnt + 3'h1;
            d.full = (q.cnt == 3'h7);
        end
        if (start) begin
            d.st = S_DEV;
            d.cnt = 3'h0;
            d.full = 1'b0;
            d.oe = 1'b0;
        end else if (stop) begin
            d.st = S_IDLE;
            d.oe = 1'b0;
        end else begin
            unique case (q.st)
                S_IDLE: ;
                S_DEV: if (fall && q.full) begin
                    d.full = 1'b0;
                    d.rw = q.sh[0];
                    d.haveSub = 1'b0;
                    d.oe = (q.sh[7:1] == DEV_ADDR);
                    d.st = (q.sh[7:1] == DEV_ADDR) ? S_DACK : S_IDLE;
                end
                S_DACK: if (fall) begin
                    d.cnt = 3'h0;
                    if (q.rw) begin
                        d.st = S_RD;
                        d.sh = regIf.rdata;
                        d.oe = ~regIf.rdata[7];
                    end else begin
                        d.st = S_WR;
                        d.oe = 1'b0;
                    end
                end
                S_WR: if (fall && q.full) begin
                    d.full = 1'b0;
                    d.oe = 1'b1;
                    d.st = S_WACK;
                    if (!q.haveSub) begin
                        d.sub = q.sh;
                        d.haveSub = 1'b1;
                    end else begin
                        d.we = 1'b1;
                    end
                end
                S_WACK: if (fall) begin
                    d.oe = 1'b0;
                    d.st = S_WR;
                    d.cnt = 3'h0;
                    if (q.haveSub && !q.acked) d.sub = q.sub + 8'h01;
                    d.acked = 1'b0;
                end
                S_RD: if (fall) begin
                    if (q.cnt == 3'h7) begin
                        d.oe = 1'b0;
                        d.st = S_RACK;
                        d.sub = q.sub + 8'h01;
                    end else begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.oe = ~q.sh[6];
                        d.cnt = q.cnt + 3'h1;
                    end
                end
                S_RACK: begin
                    if (rise) d.acked = ~sdaH;
                    if (fall) begin
                        d.acked = 1'b0;
                        d.cnt = 3'h0;
                        d.st = q.acked ? S_RD : S_IDLE;
                        d.sh = regIf.rdata;
                        d.oe = q.acked & ~regIf.rdata[7];
                    end
                end
            endcase
        end
        // First data byte only sets the subaddress, so it is not incremented
        if (q.st == S_WR && fall && q.full && !q.haveSub) d.acked = 1'b1;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q <= '{st: S_IDLE, scl: 3'h7, sda: 3'h7, sub: 8'h00, sh: 8'h00,
                   default: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign regIf.addr  = q.sub;
    assign regIf.wdata = q.sh;
    assign regIf.we    = q.we;
    assign sdaOe       = q.oe;
    assign sdaOut      = 1'b0;
endmodule // scs_i2c_slave

// [rtl/scs_task_unit.sv]
/*
 * Task flag, field skipping and output field identifier of the scaler.
 * Assumes taskStart and fieldTick are one-cycle pulses on core_clk.
 */
`timescale 1ns/1ps
module scs_task_unit (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       outFieldIdSource,
    input  wire logic       savEavMsbInvert,
    input  wire logic [2:0] fieldSkipCount,
    input  wire logic       taskStart,
    input  wire logic       fieldTick,
    input  wire logic       inFieldId,
    output logic            outFieldId,
    output logic            taskFlag,
    output logic            refMsb,
    output logic            taskGo
);
    typedef struct packed {
        logic [2:0] skip;
        logic       waiting;
        logic       toggle;
        logic       go;
        logic       fid;
        logic       flag;
        logic       msb;
    } scs_task_type;

    scs_task_type q, d;

    always_comb begin
        d = q;
        d.go = 1'b0;
        if (taskStart) begin
            d.waiting = (fieldSkipCount != 3'h0);
            d.go = (fieldSkipCount == 3'h0);
            d.skip = fieldSkipCount;
        end else if (q.waiting && fieldTick) begin
            d.skip = q.skip - 3'h1;
            d.waiting = (q.skip != 3'h1);
            d.go = (q.skip == 3'h1);
        end
        if (d.go) d.toggle = ~q.toggle;
        d.flag = ~(d.toggle ^ savEavMsbInvert);
        d.msb = ~savEavMsbInvert;
        d.fid = outFieldIdSource ? d.flag : inFieldId;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q <= '{skip: 3'h0, flag: 1'b1, msb: 1'b1, default: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign outFieldId = q.fid;
    assign taskFlag   = q.flag;
    assign refMsb     = q.msb;
    assign taskGo     = q.go;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_field_follow: assert property (!outFieldIdSource |=>
        outFieldId == $past(inFieldId)) else $error("field id not from input");
    chk_skip_zero: assert property (taskStart && fieldSkipCount == 3'h0
        |=> taskGo) else $error("zero skip did not start task");
    chk_skip_wait: assert property (taskStart && fieldSkipCount == 3'h2
        ##1 (!taskStart && !fieldTick)[*2] |-> !taskGo) else $error("task ran early");
    chk_msb_level: assert property (1'b1 |=>
        refMsb == !$past(savEavMsbInvert)) else $error("msb level wrong");
    chk_flag_toggle: assert property (taskGo
        && $past(savEavMsbInvert) == $past(savEavMsbInvert, 2)
        |-> taskFlag != $past(taskFlag)) else $error("flag did not toggle");
    cov_skip_run: cover property (taskStart && fieldSkipCount == 3'h7);
endmodule // scs_task_unit

// [rtl/scs_ctrl_regs.sv]
/*
 * Scaler control and status register bank behind an I2C-bus slave:
 * ADC bypass selection, soft reset, power-down controls, live status
 * byte and the two task handling register sets.
 * Assumes status flags and ADC samples come from logic on core_clk;
 * the two tristate pins are asynchronous.
 */
// Notes on behaviour
// - Programmed marker clears to zero on reset.
// - Marker mirrored to status D3 for checks.
// - Soft reset zero holds scaler idle.
// - Two-bit select routes ADC1..4 to bypass.
// - Decoder sleep; scaler runs only on expansion.
// - Scaler sleep powers down, stops image port.
// - Audio sleep disables audio clock outputs.
// - Status byte read-only, live, never latched.
// - D7/D6 report the two tristate pins.
// - D5 almost-filled, D4 overflow FIFO flags.
// - D2 shows output formatter rate error.
// - D1 input field, D0 output field.
// - Output field from input or task flag.
// - Invert bit sets reference msb and flag.
// - Skip zero to seven fields before task.
// - Task bits exist in sets A and B.
`timescale 1ns/1ps
module scs_ctrl_regs #(
    parameter int         ADC_W    = scs_pkg::SCS_ADC_W,
    parameter logic [6:0] DEV_ADDR = scs_pkg::SCS_I2C_DEV_ADDR
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic                  sclPin,
    input  wire logic                  sdaIn,
    output logic                       sdaOut,
    output logic                       sdaOe,
    input  wire logic [3:0][ADC_W-1:0] adcSample,
    input  wire logic                  expansionTristatePin,
    input  wire logic                  imageTristatePin,
    input  wire logic                  fifoAlmostFilled,
    input  wire logic                  fifoOverflow,
    input  wire logic                  outputFormatterError,
    input  wire logic                  scalerInputFieldId,
    input  wire logic                  scalerSrcExpansion,
    input  wire logic                  imagePortClockExpansion,
    input  wire logic                  taskSetB,
    input  wire logic                  taskStart,
    input  wire logic                  fieldTick,
    output logic [ADC_W-1:0]           adcBypassPort,
    output logic                       scalerIdle,
    output logic                       decoderPowerDown,
    output logic                       scalerPowerDown,
    output logic                       scalerRun,
    output logic                       imagePortEnable,
    output logic                       audioClockPowerDown,
    output logic                       audioClockEnable,
    output logic                       scalerOutputFieldId,
    output logic                       taskFlag,
    output logic                       timingRefMsb,
    output logic                       taskGo
);
    typedef struct packed {
        logic [7:0]       ctl;
        logic [7:0]       setA;
        logic [7:0]       setB;
        logic [1:0]       expansion_tristate_pin;
        logic [1:0]       image_tristate_pin;
        logic [ADC_W-1:0] bypass;
        logic             idle;
        logic             decPd;
        logic             sclPd;
        logic             run;
        logic             ipEn;
        logic             audPd;
        logic             audEn;
    } scs_main_type;

    scs_main_type q, d;
    scs_reg_if    regIf ();
    logic [7:0]   statusWord;
    logic [7:0]   taskCfg;

    function automatic logic isAt(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    scs_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_i2c (
        .core_clk (core_clk),
        .reset    (reset),
        .sclPin   (sclPin),
        .sdaIn    (sdaIn),
        .sdaOut   (sdaOut),
        .sdaOe    (sdaOe),
        .regIf    (regIf.bus)
    );

    // Active task register set picks the task unit configuration
    assign taskCfg = taskSetB ? q.setB : q.setA;

    scs_task_unit u_task (
        .core_clk         (core_clk),
        .reset            (reset),
        .outFieldIdSource (taskCfg[scs_pkg::SCS_OFID_BIT]),
        .savEavMsbInvert  (taskCfg[scs_pkg::SCS_MSBINV_BIT]),
        .fieldSkipCount   (taskCfg[scs_pkg::SCS_SKIP_LSB +: 3]),
        .taskStart        (taskStart),
        .fieldTick        (fieldTick),
        .inFieldId        (scalerInputFieldId),
        .outFieldId       (scalerOutputFieldId),
        .taskFlag         (taskFlag),
        .refMsb           (timingRefMsb),
        .taskGo           (taskGo)
    );

    // Status is assembled combinationally so a read sees the flags live
    always_comb begin
        statusWord = 8'h00;
        statusWord[scs_pkg::SCS_ST_EXPANSION_TRISTATE_PIN] = q.expansion_tristate_pin[1];
        statusWord[scs_pkg::SCS_ST_IMAGE_TRISTATE_PIN] = q.image_tristate_pin[1];
        statusWord[scs_pkg::SCS_ST_FIFO_ALMOST_FILLED] = fifoAlmostFilled;
        statusWord[scs_pkg::SCS_ST_FIFO_OVERFLOW] = fifoOverflow;
        statusWord[scs_pkg::SCS_ST_MARK] = q.ctl[scs_pkg::SCS_MARK_BIT];
        statusWord[scs_pkg::SCS_ST_ERR]  = outputFormatterError;
        statusWord[scs_pkg::SCS_ST_FIDI] = scalerInputFieldId;
        statusWord[scs_pkg::SCS_ST_FIDO] = scalerOutputFieldId;
    end

    always_comb begin
        if (isAt(regIf.addr, scs_pkg::SCS_ADDR_CTRL)) begin
            regIf.rdata = q.ctl;
        end else if (isAt(regIf.addr, scs_pkg::SCS_ADDR_STATUS)) begin
            regIf.rdata = statusWord;
        end else if (isAt(regIf.addr, scs_pkg::SCS_ADDR_SET_A)) begin
            regIf.rdata = q.setA;
        end else if (isAt(regIf.addr, scs_pkg::SCS_ADDR_SET_B)) begin
            regIf.rdata = q.setB;
        end else begin
            regIf.rdata = 8'h00;
        end
    end

    always_comb begin
        d = q;
        // Index 0 is the first sync stage, read only by index 1
        d.expansion_tristate_pin = {q.expansion_tristate_pin[0], expansionTristatePin};
        d.image_tristate_pin = {q.image_tristate_pin[0], imageTristatePin};
        if (regIf.we) begin
            // Status address takes no write
            if (isAt(regIf.addr, scs_pkg::SCS_ADDR_CTRL))
                d.ctl = regIf.wdata & scs_pkg::SCS_CTRL_WMASK;
            if (isAt(regIf.addr, scs_pkg::SCS_ADDR_SET_A))
                d.setA = regIf.wdata & scs_pkg::SCS_TASK_WMASK;
            if (isAt(regIf.addr, scs_pkg::SCS_ADDR_SET_B))
                d.setB = regIf.wdata & scs_pkg::SCS_TASK_WMASK;
        end
        d.bypass = adcSample[q.ctl[scs_pkg::SCS_SEL_LSB +: 2]];
        d.idle   = ~q.ctl[scs_pkg::SCS_SCALER_SOFT_RESET_N_BIT];
        d.decPd  = q.ctl[scs_pkg::SCS_DEC_SLP_BIT];
        d.sclPd  = q.ctl[scs_pkg::SCS_SCL_SLP_BIT];
        d.ipEn   = ~q.ctl[scs_pkg::SCS_SCL_SLP_BIT];
        // Decoder asleep leaves only an expansion-fed scaler alive
        d.run    = q.ctl[scs_pkg::SCS_SCALER_SOFT_RESET_N_BIT] & ~q.ctl[scs_pkg::SCS_SCL_SLP_BIT]
                   & (~q.ctl[scs_pkg::SCS_DEC_SLP_BIT]
                      | (scalerSrcExpansion & imagePortClockExpansion));
        d.audPd  = q.ctl[scs_pkg::SCS_AUD_SLP_BIT];
        d.audEn  = ~q.ctl[scs_pkg::SCS_AUD_SLP_BIT];
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            q <= '{ctl: scs_pkg::SCS_CTRL_RESET,
                   setA: scs_pkg::SCS_TASK_RESET,
                   setB: scs_pkg::SCS_TASK_RESET,
                   expansion_tristate_pin: 2'h0, image_tristate_pin: 2'h0, bypass: '0,
                   idle: 1'b1, decPd: 1'b0, sclPd: 1'b0, run: 1'b0,
                   ipEn: 1'b1, audPd: 1'b0, audEn: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign adcBypassPort       = q.bypass;
    assign scalerIdle          = q.idle;
    assign decoderPowerDown    = q.decPd;
    assign scalerPowerDown     = q.sclPd;
    assign scalerRun           = q.run;
    assign imagePortEnable     = q.ipEn;
    assign audioClockPowerDown = q.audPd;
    assign audioClockEnable    = q.audEn;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    logic ctlWr;
    assign ctlWr = regIf.we && isAt(regIf.addr, scs_pkg::SCS_ADDR_CTRL);

    chk_marker_cleared: assert property ($past(reset) |->
        !q.ctl[scs_pkg::SCS_MARK_BIT]) else $error("marker not clear after reset");
    chk_marker_mirror: assert property (ctlWr |=>
        statusWord[scs_pkg::SCS_ST_MARK] == $past(regIf.wdata[scs_pkg::SCS_MARK_BIT]))
        else $error("marker not mirrored");
    chk_soft_reset_idle: assert property (ctlWr && !regIf.wdata[scs_pkg::SCS_SCALER_SOFT_RESET_N_BIT]
        |=> ##1 scalerIdle && !scalerRun) else $error("scaler not idle");
    chk_bypass_select: assert property ($stable(q.ctl) && $stable(adcSample) |=>
        adcBypassPort == $past(adcSample[q.ctl[scs_pkg::SCS_SEL_LSB +: 2]]))
        else $error("wrong ADC on bypass port");
    chk_decoder_sleep: assert property (q.ctl[scs_pkg::SCS_DEC_SLP_BIT]
        && !(scalerSrcExpansion && imagePortClockExpansion) |=> !scalerRun && decoderPowerDown)
        else $error("scaler ran with decoder asleep");
    chk_scaler_sleep: assert property (ctlWr && regIf.wdata[scs_pkg::SCS_SCL_SLP_BIT]
        |=> ##1 scalerPowerDown && !imagePortEnable) else $error("image port not stopped");
    chk_audio_sleep: assert property (q.ctl[scs_pkg::SCS_AUD_SLP_BIT] |=>
        audioClockPowerDown && !audioClockEnable) else $error("audio clock still on");
    chk_status_live: assert property (isAt(regIf.addr, scs_pkg::SCS_ADDR_STATUS) |->
        regIf.rdata[5:4] == {fifoAlmostFilled, fifoOverflow}
        && regIf.rdata[2] == outputFormatterError) else $error("status not live");
    chk_pin_flags: assert property ($stable(expansionTristatePin)[*3] |->
        statusWord[scs_pkg::SCS_ST_EXPANSION_TRISTATE_PIN] == expansionTristatePin) else $error("pin flag stale");
    chk_unused_zero: assert property (1'b1 |-> !q.ctl[2])
        else $error("unused control bit set");
    chk_set_b_store: assert property (regIf.we && isAt(regIf.addr, scs_pkg::SCS_ADDR_SET_B)
        |=> q.setB[7:3] == $past(regIf.wdata[7:3]) && $stable(q.setA))
        else $error("set B write wrong");

    cov_ctl_write: cover property (ctlWr && regIf.wdata[scs_pkg::SCS_SCALER_SOFT_RESET_N_BIT]);
    cov_status_read: cover property (isAt(regIf.addr, scs_pkg::SCS_ADDR_STATUS));
    cov_task_go: cover property (taskSetB && taskGo);
endmodule // scs_ctrl_regs

// [tb/scs_i2c_host.sv]
/* I2C-bus host model that reaches the register bank.
   Assumes a pull-up on SDA; bit timing is paced by core_clk. */
`timescale 1ns/1ps
module scs_i2c_host (
    core_clk,
    sdaOe,
    sclPin,
    sdaIn
);
    input  wire logic core_clk;
    input  wire logic sdaOe;
    output logic      sclPin;
    output logic      sdaIn;
    logic hostLow = 1'b0;
    // Wired-AND with pull-up, so a released line reads high
    assign sdaIn = !(hostLow || sdaOe);
    initial sclPin = 1'b1;
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Doubles as repeated start when entered with SCL low
    task automatic start();
        hostLow = 1'b0;
        wt(4);
        sclPin = 1'b1;
        wt(10);
        hostLow = 1'b1;
        wt(10);
        sclPin = 1'b0;
        wt(4);
    endtask
    task automatic stop();
        hostLow = 1'b1;
        wt(4);
        sclPin = 1'b1;
        wt(10);
        hostLow = 1'b0;
        wt(10);
    endtask
    // SDA moves only well after SCL fell, never near a START/STOP edge
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            hostLow = !tx[i];
            wt(6);
            sclPin = 1'b1;
            wt(10);
            rx[i] = sdaIn;
            sclPin = 1'b0;
            wt(4);
        end
    endtask
endmodule // scs_i2c_host

// [tb/scaler_control_status_regs_tb.sv]
/* Self-checking bench for the scaler control/status registers.
   Assumes the design answers at the default bus device address. */
`timescale 1ns/1ps
module scaler_control_status_regs_tb;
    logic core_clk, reset, sclPin, sdaIn, sdaOut, sdaOe;
    logic [3:0][8:0] adcSample;
    logic expansionTristatePin, imageTristatePin, fifoAlmostFilled, fifoOverflow;
    logic outputFormatterError, scalerInputFieldId, scalerSrcExpansion;
    logic imagePortClockExpansion, taskSetB, taskStart, fieldTick, taskGo;
    logic [8:0] adcBypassPort;
    logic scalerIdle, decoderPowerDown, scalerPowerDown, scalerRun, imagePortEnable;
    logic audioClockPowerDown, audioClockEnable, scalerOutputFieldId, taskFlag;
    logic timingRefMsb;
    int errCount = 0;
    int cmpCount = 0;
    scs_ctrl_regs scs_ctrl_regs_inst (.*);
    scs_i2c_host scs_i2c_host_inst (.*);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = !core_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string m);
        cmpCount++;
        if (got !== exp) begin
            errCount++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic acc(input logic [7:0] a, input logic rd, inout logic [7:0] d);
        logic [8:0] r0, r1, r2;
        scs_i2c_host_inst.start();
        scs_i2c_host_inst.xfer({scs_pkg::SCS_I2C_DEV_ADDR, 2'b01}, r0);
        scs_i2c_host_inst.xfer({a, 1'b1}, r1);
        if (rd) begin
            scs_i2c_host_inst.start();
            scs_i2c_host_inst.xfer({scs_pkg::SCS_I2C_DEV_ADDR, 2'b11}, r0);
            // Host leaves the ninth bit released: no ack ends the read
            scs_i2c_host_inst.xfer(9'h1ff, r2);
            d = r2[8:1];
        end else begin
            scs_i2c_host_inst.xfer({d, 1'b1}, r2);
        end
        scs_i2c_host_inst.stop();
        chk({r0[0], r1[0], r2[0] & !rd}, 9'h000, "missing ack");
        chk(sdaOut, 1'b0, "sda drive level");
    endtask
    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", cmpCount, errCount);
        if (errCount == 0 && cmpCount > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        logic [7:0] v, d, t;
        logic g, f;
        logic [2:0] n;
        reset = 1'b1;
        adcSample = '0;
        {expansionTristatePin, imageTristatePin, fifoAlmostFilled, fifoOverflow} = 4'h0;
        {outputFormatterError, scalerInputFieldId, scalerSrcExpansion} = 3'h0;
        {imagePortClockExpansion, taskSetB, taskStart, fieldTick} = 4'h0;
        void'($urandom(65));
        cyc(20);
        reset = 1'b0;
        cyc(5);
        acc(scs_pkg::SCS_ADDR_CTRL, 1'b1, d);
        chk(d, 9'h000, "ctrl reset");
        chk({scalerIdle, imagePortEnable, audioClockEnable, scalerRun}, 9'he, "idle");
        acc(8'h55, 1'b1, d);
        chk(d, 9'h000, "unmapped read");
        for (int s = 0; s < 4; s++) begin
            foreach (adcSample[i]) adcSample[i] = 9'($urandom);
            {expansionTristatePin, imageTristatePin, fifoAlmostFilled, fifoOverflow,
             outputFormatterError, scalerInputFieldId, scalerSrcExpansion,
             imagePortClockExpansion} = 8'($urandom);
            v = {2'(s), 6'($urandom)};
            acc(scs_pkg::SCS_ADDR_CTRL, 1'b0, v);
            acc(scs_pkg::SCS_ADDR_CTRL, 1'b1, d);
            chk(d, v & 8'hfb, "ctrl readback");
            chk(adcBypassPort, adcSample[s], "bypass");
            chk(scalerIdle, !v[5], "soft reset");
            chk({decoderPowerDown, scalerPowerDown, imagePortEnable}, {v[0], v[1], !v[1]}, "pd");
            chk({audioClockPowerDown, audioClockEnable}, {v[3], !v[3]}, "audio");
            chk(scalerRun, v[5] & !v[1] & (!v[0] | (scalerSrcExpansion & imagePortClockExpansion)), "run");
            acc(scs_pkg::SCS_ADDR_STATUS, 1'b1, d);
            chk(d, {expansionTristatePin, imageTristatePin, fifoAlmostFilled, fifoOverflow, v[4], outputFormatterError, scalerInputFieldId, scalerInputFieldId}, "status");
        end
        for (int k = 0; k < 4; k++) begin
            n = (k == 0) ? 3'd0 : (k == 1) ? 3'd7 : 3'($urandom);
            t = {k[0], 1'b1, n, 3'b000};
            taskSetB = k[1];
            acc(k[1] ? scs_pkg::SCS_ADDR_SET_B : scs_pkg::SCS_ADDR_SET_A, 1'b0, t);
            acc(k[1] ? scs_pkg::SCS_ADDR_SET_B : scs_pkg::SCS_ADDR_SET_A, 1'b1, d);
            chk(d, t, "task set");
            chk(timingRefMsb, !t[7], "ref msb");
            f = taskFlag;
            g = 1'b0;
            taskStart = 1'b1;
            cyc(1);
            taskStart = 0;
            for (int j = 0; j < n; j++) begin
                repeat (3) begin
                    g |= taskGo;
                    cyc(1);
                end
                fieldTick = 1'b1;
                cyc(1);
                fieldTick = 1'b0;
            end
            chk(g, 1'b0, "early task");
            repeat (4) begin
                g |= taskGo;
                cyc(1);
            end
            chk(g, 1'b1, "task late");
            cyc(2);
            chk(taskFlag, !f, "flag toggle");
            chk(scalerOutputFieldId, !f, "out field");
        end
        printVerdict();
    end
endmodule // scaler_control_status_regs_tb
